// file: hdl/cwk_pkg.sv
/*
  Shared constants, types and decode helpers for the clear and watchdog-kick
  execution block: opcode patterns, timing figures, status layout, register
  offsets and reset values.
  Assumes a single 25 MHz core clock that also serves as the oscillator.
*/
`default_nettype none

package cwk_pkg;

  // ==========================================================================
  // Widths and opcode patterns
  localparam int CWK_INSTR_W = 14;
  localparam int CWK_DATA_W = 8;
  localparam int CWK_FADDR_W = 7;
  localparam int CWK_IRQ_W = 4;
  // Upper seven opcode bits for the clears, address or don't-care below; kick is a full 14-bit word
  localparam logic [6:0] CWK_OPC_CLR_FILE = 7'h03;
  localparam logic [6:0] CWK_OPC_CLR_ACC = 7'h02;
  localparam logic [13:0] CWK_OPC_KICK = 14'h0064;
  localparam logic [7:0] CWK_ZERO_BYTE = 8'h00;

  // ==========================================================================
  // Timing
  localparam int CWK_CLK_HZ = 25_000_000;
  localparam int CWK_WDOG_NOM_MS = 18;
  localparam int CWK_WDOG_MIN_MS = 7;
  localparam int CWK_WDOG_MAX_MS = 33;
  localparam int CWK_WDOG_NOM_CYC = CWK_WDOG_NOM_MS * (CWK_CLK_HZ / 1000);
  localparam int CWK_WDOG_MIN_CYC = (CWK_WDOG_MIN_MS * CWK_CLK_HZ + 999) / 1000;
  localparam int CWK_WDOG_MAX_CYC = (CWK_WDOG_MAX_MS * CWK_CLK_HZ) / 1000;
  localparam int CWK_WDOG_STEPS = 256;
  localparam int CWK_PHASES = 4;

  // ==========================================================================
  // Status byte layout and reset values
  localparam int CWK_ST_C = 0;
  localparam int CWK_ST_DC = 1;
  localparam int CWK_ST_Z = 2;
  localparam int CWK_ST_PWRDN_N = 3;
  localparam int CWK_ST_EXPIRY_N = 4;
  localparam logic [7:0] CWK_STATUS_RST = 8'h18;
  localparam logic [7:0] CWK_STATUS_SW_MASK = 8'h03;
  localparam logic [7:0] CWK_ACC_RST = 8'h00;

  // ==========================================================================
  // Control register fields
  localparam int CWK_CT_OSC = 0;
  localparam int CWK_CT_WDEN = 1;
  localparam int CWK_CT_PSEL = 2;
  localparam int CWK_CTRL_W = 5;
  localparam logic [4:0] CWK_CTRL_RST = 5'h03;

  // ==========================================================================
  // Interrupt bits
  localparam int CWK_IRQ_CLR_FILE = 0;
  localparam int CWK_IRQ_CLR_ACC = 1;
  localparam int CWK_IRQ_KICK = 2;
  localparam int CWK_IRQ_WDOG = 3;
  localparam logic [3:0] CWK_IMASK_RST = 4'h0;
  localparam logic [3:0] CWK_ISTAT_RST = 4'h0;

  // ==========================================================================
  // Register byte offsets
  localparam logic [4:0] CWK_OFF_CTRL = 5'h00;
  localparam logic [4:0] CWK_OFF_STATUS = 5'h04;
  localparam logic [4:0] CWK_OFF_ACCUM = 5'h08;
  localparam logic [4:0] CWK_OFF_WDOG = 5'h0C;
  localparam logic [4:0] CWK_OFF_ISTAT = 5'h10;
  localparam logic [4:0] CWK_OFF_IMASK = 5'h14;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {CWK_Q1, CWK_Q2, CWK_Q3, CWK_Q4} cwk_phase_e;
  typedef enum logic [1:0] {CWK_OP_NONE, CWK_OP_CLR_FILE, CWK_OP_CLR_ACC, CWK_OP_KICK} cwk_op_e;

  // Opcode classification shared by execution and checks
  function automatic cwk_op_e cwk_decode(input logic [13:0] w);
    cwk_op_e op;
    op = CWK_OP_NONE;
    if (w[13:7] == CWK_OPC_CLR_FILE)
      op = CWK_OP_CLR_FILE;
    else if (w[13:7] == CWK_OPC_CLR_ACC)
      op = CWK_OP_CLR_ACC;
    else if (w == CWK_OPC_KICK)
      op = CWK_OP_KICK;
    return op;
  endfunction

endpackage

`default_nettype wire

// file: hdl/cwk_phase_gen.sv
/*
  Four-phase instruction-cycle sequencer with the cycle clock output.
  Assumes the oscillator is the block clock and osc_mode comes from logic
  on that same clock.
*/
`default_nettype none

module cwk_phase_gen
  import cwk_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic osc_mode,
  output var cwk_pkg::cwk_phase_e phase,
  output logic cycle_clock_output
);

  cwk_phase_e next_phase;

  // ==========================================================================
  // Phase sequence
  always_comb
  begin
    case (phase)
      CWK_Q1: next_phase = CWK_Q2;
      CWK_Q2: next_phase = CWK_Q3;
      CWK_Q3: next_phase = CWK_Q4;
      CWK_Q4: next_phase = CWK_Q1;
      default: next_phase = CWK_Q1;
    endcase
  end

  // Phase register and divide-by-four clock, high in Q3 and Q4
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      phase <= CWK_Q1;
      cycle_clock_output <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      cycle_clock_output <= osc_mode && (next_phase == CWK_Q3 || next_phase == CWK_Q4);
    end
  end

endmodule

`default_nettype wire

// file: hdl/cwk_exec.sv
/*
  Execution logic for the clear-file, clear-accumulator and watchdog-kick
  instructions, with watchdog chain, status flags, interrupt and an
  Avalon-MM register slave.
  Assumes the core presents instructions on ref_clk at phase Q1, and that
  sleep_active and ext_reset_req come from logic on the same clock.
*/
// Function
// - Clear-file zeroes the addressed file register and sets the zero flag.
// - Clear-accumulator zeroes the accumulator and sets the zero flag.
// - Watchdog kick zeroes the watchdog counter in the fourth phase.
// - Watchdog kick also zeroes the prescaler so the chain restarts fully.
// - Watchdog kick sets the expiry and power-down flags (active low) to one.
// - Each clear instruction is one word and completes in one four-phase cycle.
// - Unprescaled watchdog expiry is nominally 18 ms, range 7 to 33 ms, as a parameter.
// - In RC oscillator mode the cycle clock output runs at four oscillator periods.
// - Expiry and power-down flags take distinct values for each reset kind except an external reset while awake, which leaves them unchanged.
`default_nettype none

module cwk_exec
  import cwk_pkg::*;
#(
  parameter int WDOG_TIMEOUT_CYC = CWK_WDOG_NOM_CYC
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic instr_valid,
  input wire logic [cwk_pkg::CWK_INSTR_W-1:0] instr_word,
  output logic instr_ready,
  output logic instr_done,
  input wire logic sleep_active,
  input wire logic ext_reset_req,
  output logic file_rd_en,
  output logic file_wr_en,
  output logic [cwk_pkg::CWK_FADDR_W-1:0] file_addr,
  output logic [cwk_pkg::CWK_DATA_W-1:0] file_wr_data,
  output logic [cwk_pkg::CWK_DATA_W-1:0] accumulator,
  output logic [7:0] status_flags,
  output logic [7:0] watchdog_counter,
  output logic watchdog_reset,
  output logic cycle_clock_output,
  output var cwk_pkg::cwk_phase_e phase
);

  // ==========================================================================
  // Watchdog divider sizing
  localparam int DIV_RAW = WDOG_TIMEOUT_CYC / CWK_WDOG_STEPS;
  localparam int DIV_LIM = (DIV_RAW > 1) ? DIV_RAW : 1;
  localparam int DIV_W = (DIV_LIM > 1) ? $clog2(DIV_LIM) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_LIM - 1);

  logic [CWK_INSTR_W-1:0] ir;
  logic ir_valid;
  logic [CWK_CTRL_W-1:0] ctrl;
  logic [CWK_IRQ_W-1:0] istat;
  logic [CWK_IRQ_W-1:0] imask;
  logic [7:0] prescaler;
  logic [DIV_W-1:0] base_div;
  logic bus_ack;
  logic [7:0] next_status;
  logic [31:0] rd_word;

  // ==========================================================================
  // Phase sequencer
  cwk_phase_gen u_phase
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .osc_mode(ctrl[CWK_CT_OSC]),
    .phase(phase),
    .cycle_clock_output(cycle_clock_output)
  );

  // ==========================================================================
  // Instruction capture and decode
  cwk_op_e ir_op;
  wire exec_q4 = ir_valid && (phase == CWK_Q4);
  wire do_clr_file = exec_q4 && (ir_op == CWK_OP_CLR_FILE);
  wire do_clr_acc = exec_q4 && (ir_op == CWK_OP_CLR_ACC);
  wire do_kick = exec_q4 && (ir_op == CWK_OP_KICK);

  assign ir_op = cwk_decode(ir);
  assign instr_ready = (phase == CWK_Q1);
  assign instr_done = exec_q4 && (ir_op != CWK_OP_NONE);

  // Word taken only in Q1, so one word per four-phase cycle
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ir <= 14'h0000;
      ir_valid <= 1'b0;
    end
    else if (phase == CWK_Q1)
    begin
      ir <= instr_word;
      ir_valid <= instr_valid;
    end
  end

  // ==========================================================================
  // File register port; address comes straight from the captured word
  assign file_addr = ir[CWK_FADDR_W-1:0];
  assign file_rd_en = ir_valid && (phase == CWK_Q2) && (ir_op == CWK_OP_CLR_FILE);
  assign file_wr_en = do_clr_file;
  assign file_wr_data = CWK_ZERO_BYTE;

  // ==========================================================================
  // Avalon decode; one wait cycle, so read data settle before release
  wire bus_req = avs_read || avs_write;
  wire wr_fire = avs_write && bus_ack;
  wire rd_load = avs_read && !bus_ack;
  wire sel_ctrl = (avs_address == CWK_OFF_CTRL);
  wire sel_status = (avs_address == CWK_OFF_STATUS);
  wire sel_accum = (avs_address == CWK_OFF_ACCUM);
  wire sel_wdog = (avs_address == CWK_OFF_WDOG);
  wire sel_istat = (avs_address == CWK_OFF_ISTAT);
  wire sel_imask = (avs_address == CWK_OFF_IMASK);
  wire wr_ctrl = wr_fire && sel_ctrl;
  wire wr_status = wr_fire && sel_status;
  wire wr_accum = wr_fire && sel_accum;
  wire wr_istat = wr_fire && sel_istat;
  wire wr_imask = wr_fire && sel_imask;

  assign avs_waitrequest = bus_req && !bus_ack;

  // Read selection, unmapped reads give zero
  assign rd_word = sel_ctrl ? {27'h0000000, ctrl} :
                   sel_status ? {24'h000000, status_flags} :
                   sel_accum ? {24'h000000, accumulator} :
                   sel_wdog ? {16'h0000, prescaler, watchdog_counter} :
                   sel_istat ? {28'h0000000, istat} :
                   sel_imask ? {28'h0000000, imask} : 32'h00000000;

  // Acknowledge and read data register
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      bus_ack <= bus_req && !bus_ack;
      if (rd_load)
        avs_readdata <= rd_word;
    end
  end

  // Control and mask registers
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ctrl <= CWK_CTRL_RST;
      imask <= CWK_IMASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= avs_writedata[CWK_CTRL_W-1:0];
      if (wr_imask)
        imask <= avs_writedata[CWK_IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // Watchdog chain: base divider, prescaler, 8-bit counter
  wire [2:0] psel = ctrl[CWK_CT_PSEL +: 3];
  wire [7:0] presc_mask = 8'((16'h0001 << psel) - 16'h0001);
  wire base_tick = (base_div == DIV_LAST);
  wire presc_tick = base_tick && (prescaler == presc_mask);
  // A kick or external reset in the expiry cycle wins: the chain was just restarted
  wire chain_restart = do_kick || ext_reset_req || !ctrl[CWK_CT_WDEN];
  wire wdog_expire = presc_tick && (watchdog_counter == 8'hFF) && !chain_restart;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst || chain_restart)
    begin
      base_div <= '0;
      prescaler <= 8'h00;
      watchdog_counter <= 8'h00;
    end
    else
    begin
      base_div <= base_tick ? '0 : base_div + DIV_W'(1);
      if (presc_tick)
        prescaler <= 8'h00;
      else if (base_tick)
        prescaler <= prescaler + 8'h01;
      if (presc_tick)
        watchdog_counter <= watchdog_counter + 8'h01;
    end
  end

  // ==========================================================================
  // Status flags; reset-kind coding and instruction effects
  always_comb
  begin
    next_status = status_flags;
    if (wr_status)
      next_status = (status_flags & ~CWK_STATUS_SW_MASK) |
                    (avs_writedata[7:0] & CWK_STATUS_SW_MASK);
    if (do_clr_file || do_clr_acc)
      next_status[CWK_ST_Z] = 1'b1;
    if (do_kick)
    begin
      next_status[CWK_ST_EXPIRY_N] = 1'b1;
      next_status[CWK_ST_PWRDN_N] = 1'b1;
    end
    if (wdog_expire)
    begin
      next_status[CWK_ST_EXPIRY_N] = 1'b0;
      next_status[CWK_ST_PWRDN_N] = !sleep_active;
    end
    if (ext_reset_req && sleep_active)
    begin
      next_status[CWK_ST_EXPIRY_N] = 1'b1;
      next_status[CWK_ST_PWRDN_N] = 1'b0;
    end
  end

  // Power-on reset codes both flags high
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      status_flags <= CWK_STATUS_RST;
    else
      status_flags <= next_status;
  end

  // Accumulator; hardware clear beats a same-cycle software write
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      accumulator <= CWK_ACC_RST;
    else if (do_clr_acc)
      accumulator <= CWK_ZERO_BYTE;
    else if (wr_accum)
      accumulator <= avs_writedata[7:0];
  end

  // Watchdog reset pulse, only when awake; asleep it is a wake-up
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      watchdog_reset <= 1'b0;
    else
      watchdog_reset <= wdog_expire && !sleep_active;
  end

  // ==========================================================================
  // Interrupt status, set wins over write-one-to-clear
  wire [CWK_IRQ_W-1:0] irq_set = {wdog_expire, do_kick, do_clr_acc, do_clr_file};
  wire [CWK_IRQ_W-1:0] irq_clr = wr_istat ? avs_writedata[CWK_IRQ_W-1:0] : 4'h0;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      istat <= CWK_ISTAT_RST;
    else
      istat <= (istat & ~irq_clr) | irq_set;
  end

  assign irq = |(istat & imask);

  // ==========================================================================
  // Checks
  sequence s_accept;
    (phase == CWK_Q1) && instr_valid && (cwk_decode(instr_word) != CWK_OP_NONE);
  endsequence

  sequence s_one_cycle;
    !instr_done ##1 !instr_done ##1 instr_done ##1 !instr_done;
  endsequence

  property p_clr_file_zero;
    @(posedge ref_clk) disable iff (!nrst)
    do_clr_file |-> (file_wr_en && file_wr_data == 8'h00 && file_addr == ir[6:0])
      ##1 status_flags[CWK_ST_Z];
  endproperty
  a_clr_file_zero: assert property (p_clr_file_zero) else $error("clear-file failed");

  property p_clr_acc_zero;
    @(posedge ref_clk) disable iff (!nrst)
    do_clr_acc |=> (accumulator == 8'h00) && status_flags[CWK_ST_Z];
  endproperty
  a_clr_acc_zero: assert property (p_clr_acc_zero) else $error("clear-acc failed");

  property p_kick_q4;
    @(posedge ref_clk) disable iff (!nrst)
    do_kick |-> (phase == CWK_Q4) ##1 (watchdog_counter == 8'h00);
  endproperty
  a_kick_q4: assert property (p_kick_q4) else $error("kick counter not cleared");

  property p_kick_presc;
    @(posedge ref_clk) disable iff (!nrst)
    do_kick |=> (prescaler == 8'h00) && (base_div == '0);
  endproperty
  a_kick_presc: assert property (p_kick_presc) else $error("prescaler not cleared");

  property p_kick_flags;
    @(posedge ref_clk) disable iff (!nrst)
    do_kick && !ext_reset_req |=>
      status_flags[CWK_ST_EXPIRY_N] && status_flags[CWK_ST_PWRDN_N];
  endproperty
  a_kick_flags: assert property (p_kick_flags) else $error("kick flags not set");

  property p_one_cycle;
    @(posedge ref_clk) disable iff (!nrst)
    s_accept |=> s_one_cycle;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("instruction not single-cycle");

  property p_cco_period;
    @(posedge ref_clk) disable iff (!nrst || !ctrl[CWK_CT_OSC])
    $rose(cycle_clock_output) |-> cycle_clock_output ##1 cycle_clock_output
      ##1 !cycle_clock_output [*2] ##1 cycle_clock_output;
  endproperty
  a_cco_period: assert property (p_cco_period) else $error("cycle clock period wrong");

  property p_wdog_reset_code;
    @(posedge ref_clk) disable iff (!nrst)
    wdog_expire && !sleep_active && !ext_reset_req |=>
      !status_flags[CWK_ST_EXPIRY_N] && status_flags[CWK_ST_PWRDN_N] && watchdog_reset;
  endproperty
  a_wdog_reset_code: assert property (p_wdog_reset_code) else $error("expiry code wrong");

  property p_wake_code;
    @(posedge ref_clk) disable iff (!nrst)
    wdog_expire && sleep_active && !ext_reset_req |=>
      !status_flags[CWK_ST_EXPIRY_N] && !status_flags[CWK_ST_PWRDN_N] && !watchdog_reset;
  endproperty
  a_wake_code: assert property (p_wake_code) else $error("wake code wrong");

  property p_kick_no_data;
    @(posedge ref_clk) disable iff (!nrst)
    do_kick && !wr_accum && !wr_status |-> !file_wr_en
      ##1 $stable(accumulator) && (status_flags[1:0] == $past(status_flags[1:0]));
  endproperty
  a_kick_no_data: assert property (p_kick_no_data) else $error("kick touched data");

endmodule

`default_nettype wire

// file: verif/tb.sv
/*
  Self-checking bench for the clear and watchdog-kick execution block.
  Assumes cwk_pkg and cwk_exec are compiled first; no partner model.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cwk_pkg::*;

  // ==========================================================================
  // Signals
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic instr_valid = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic instr_ready;
  logic instr_done;
  logic sleep_active = 1'b0;
  logic ext_reset_req = 1'b0;
  logic file_rd_en;
  logic file_wr_en;
  logic [6:0] file_addr;
  logic [7:0] file_wr_data;
  logic [7:0] accumulator;
  logic [7:0] status_flags;
  logic [7:0] watchdog_counter;
  logic watchdog_reset;
  logic cycle_clock_output;
  cwk_phase_e phase;
  int n_fail = 0;
  int total_checks = 0;

  // Short watchdog so an expiry takes 512 cycles
  cwk_exec #(.WDOG_TIMEOUT_CYC(512)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .instr_done(instr_done),
    .sleep_active(sleep_active), .ext_reset_req(ext_reset_req), .file_rd_en(file_rd_en),
    .file_wr_en(file_wr_en), .file_addr(file_addr), .file_wr_data(file_wr_data),
    .accumulator(accumulator), .status_flags(status_flags),
    .watchdog_counter(watchdog_counter), .watchdog_reset(watchdog_reset),
    .cycle_clock_output(cycle_clock_output), .phase(phase)
  );

  // ==========================================================================
  // Clock, 40 ns period
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Reporting
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tmo(input string nm);
    n_fail++;
    $display("Error %s expected answer seen timeout", nm);
    finish_test();
  endtask

  // ==========================================================================
  // Bus and instruction drivers
  // Request held until waitrequest is sampled low at a rising edge
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (i == 20)
      tmo("avalon");
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask

  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
  endtask

  // Word offered in Q1, done checked in Q4, returns once effects land
  task automatic exec(input logic [13:0] w, input logic dn);
    int i;
    for (i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      if (phase === CWK_Q4)
        break;
    end
    if (i == 8)
      tmo("phase");
    instr_valid <= 1'b1;
    instr_word <= w;
    #1;
    chk("ready", {31'h0, instr_ready}, 32'h1);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    chk("rd_en", {31'h0, file_rd_en}, {31'h0, dn && w[13:7] == CWK_OPC_CLR_FILE});
    repeat (2) @(posedge ref_clk);
    #1;
    chk("done", {31'h0, instr_done}, {31'h0, dn});
    chk("phase", phase, CWK_Q4);
    chk("wr_en", {31'h0, file_wr_en}, {31'h0, dn && w[13:7] == CWK_OPC_CLR_FILE});
    @(posedge ref_clk);
    #1;
  endtask

  // Waits for an expiry, awake or asleep
  task automatic wdog_wait(output int n);
    for (n = 0; n < 1200; n++)
    begin
      @(posedge ref_clk);
      #1;
      if (watchdog_reset === 1'b1 || (sleep_active && status_flags[CWK_ST_PWRDN_N] === 1'b0))
        break;
    end
    if (n == 1200)
      tmo("watchdog");
    @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse_ext();
    @(posedge ref_clk);
    ext_reset_req <= 1'b1;
    @(posedge ref_clk);
    ext_reset_req <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    int n;
    int i;
    // Clear-file at the top address, from a fresh reset where Z is low
    do_reset();
    rdc("ctrl", CWK_OFF_CTRL, 32'h3);
    rdc("status", CWK_OFF_STATUS, 32'h18);
    rdc("unmapped", 5'h18, 32'h0);
    chk("nominal", CWK_WDOG_NOM_CYC, 32'h0006DDD0);
    wr(CWK_OFF_IMASK, 32'hF);
    exec({CWK_OPC_CLR_FILE, 7'h7F}, 1'b1);
    chk("faddr", file_addr, 7'h7F);
    chk("fdata", file_wr_data, 8'h00);
    chk("status", status_flags, 8'h1C);
    chk("irq", irq, 1'b1);
    wr(CWK_OFF_ISTAT, 32'h1);
    #1;
    chk("irq", irq, 1'b0);
    exec({CWK_OPC_CLR_FILE, 7'h00}, 1'b1);
    chk("faddr", file_addr, 7'h00);
    $display("test clear_file done");
    // Clear-accumulator with carry bits set and don't-care bits nonzero
    do_reset();
    wr(CWK_OFF_ACCUM, 32'h5A);
    wr(CWK_OFF_STATUS, 32'h3);
    exec(14'h0063, 1'b0);
    chk("acc", accumulator, 8'h5A);
    exec({CWK_OPC_CLR_ACC, 7'h55}, 1'b1);
    chk("acc", accumulator, 8'h00);
    chk("status", status_flags, 8'h1F);
    rdc("accum", CWK_OFF_ACCUM, 32'h0);
    $display("test clear_accumulator done");
    // Watchdog expiry awake, kick, then expiry and external reset asleep
    do_reset();
    wr(CWK_OFF_ACCUM, 32'h3C);
    wr(CWK_OFF_IMASK, 32'h8);
    wdog_wait(n);
    chk("status", status_flags, 8'h08);
    chk("irq", irq, 1'b1);
    exec(CWK_OPC_KICK, 1'b1);
    chk("wdog", watchdog_counter, 8'h00);
    chk("status", status_flags, 8'h18);
    chk("acc", accumulator, 8'h3C);
    wdog_wait(n);
    chk("period", {31'h0, n >= 505 && n <= 516}, 32'h1);
    @(posedge ref_clk);
    sleep_active <= 1'b1;
    wdog_wait(n);
    chk("status", status_flags, 8'h00);
    pulse_ext();
    chk("status", status_flags, 8'h10);
    @(posedge ref_clk);
    sleep_active <= 1'b0;
    pulse_ext();
    chk("status", status_flags, 8'h10);
    exec(CWK_OPC_KICK, 1'b1);
    chk("status", status_flags, 8'h18);
    wr(CWK_OFF_IMASK, 32'h0);
    #1;
    chk("irq", irq, 1'b0);
    // Prescale select one doubles the expiry time after a kick
    wr(CWK_OFF_CTRL, 32'h7);
    exec(CWK_OPC_KICK, 1'b1);
    wdog_wait(n);
    chk("period2", {31'h0, n >= 1020 && n <= 1028}, 32'h1);
    $display("test watchdog done");
    // Cycle clock high in Q3 and Q4 only, off when the mode bit is clear
    for (i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      #1;
      chk("cco", cycle_clock_output, phase === CWK_Q3 || phase === CWK_Q4);
    end
    wr(CWK_OFF_CTRL, 32'h2);
    for (i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      #1;
      chk("cco", cycle_clock_output, 1'b0);
    end
    $display("test cycle_clock done");
    finish_test();
  end
endmodule

`default_nettype wire
